// ### rtl/swcs_top.sv
// Purpose: Switching frequency select, sync lock, slewing and shutdown control
// Assumes: ADC result arrives on the core clock; pins are asynchronous
// Notes: Frequency output is a kHz word for the analog oscillator
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R1] Floating address strap at init selects analog mode, else digital mode.
// [R2] Analog mode fixes frequency from one 10-bit ADC read during init.
// [R3] After init the pin is never sampled again for frequency.
// [R4] ADC code decodes into sixteen steps, 306 kHz up to 1500 kHz.
// [R5] Digital mode starts at 607 kHz, bus programmable 250 to 1500 kHz.
// [R6] Host should prefer odd frequencies such as 251 or 1454 kHz.
// [R7] Sync present at analog init must stay applied by the source.
// [R8] Analog sync lost after being present at init disables conversion.
// [R9] Sync first seen after init falls back to free-running on loss.
// [R10] Digital free-running frequency comes from register, sync taken directly.
// [R11] Applied sync clock is approached gradually, up or down.
// [R12] Removed sync clock slews gradually back to free-running frequency.
// [R13] Enable low turns both drivers off at once, no soft stop.
// [R14] Digital mode may also accept shutdown through operation command bit.
// [R15] Sync lost when no edge within window longer than longest period.
module swcs_top #(
    parameter int FREQ_W = 12
) (
    input wire logic i_core_clk, // Core clock, 25 MHz
    input wire logic i_srst, // Synchronous reset, active high
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB access phase
    input wire logic i_pwrite, // APB write
    input wire logic [7:0] i_paddr, // APB byte address
    input wire logic [31:0] i_pwdata, // APB write data
    output logic [31:0] o_prdata, // APB read data
    output logic o_pready, // APB ready
    output logic o_pslverr, // APB error, unmapped address
    input wire logic i_addr_float, // Address strap pin floating, async
    input wire logic i_freq_set_sync_pin, // Sync clock level on pin, async
    input wire logic i_enable, // Enable pin, async
    output logic o_adc_req, // ADC conversion request, level
    input wire logic i_adc_valid, // ADC result strobe
    input wire logic [9:0] i_adc_data, // ADC result
    output logic [FREQ_W-1:0] o_fsw_khz, // Switching frequency now, kHz
    output logic o_hs_drv_en, // High-side driver enable
    output logic o_ls_drv_en, // Low-side driver enable
    output logic o_irq // Interrupt, level
);
    typedef enum logic [1:0] {ST_STRAP, ST_ADC, ST_RUN} swcs_state_e;

    // Analog resistor decode table, kHz
    function automatic logic [FREQ_W-1:0] f_step_khz(input logic [3:0] idx);
        case (idx)
            4'h0: f_step_khz = FREQ_W'(306);
            4'h1: f_step_khz = FREQ_W'(356);
            4'h2: f_step_khz = FREQ_W'(400);
            4'h3: f_step_khz = FREQ_W'(444);
            4'h4: f_step_khz = FREQ_W'(500);
            4'h5: f_step_khz = FREQ_W'(550);
            4'h6: f_step_khz = FREQ_W'(600);
            4'h7: f_step_khz = FREQ_W'(706);
            4'h8: f_step_khz = FREQ_W'(750);
            4'h9: f_step_khz = FREQ_W'(800);
            4'ha: f_step_khz = FREQ_W'(923);
            4'hb: f_step_khz = FREQ_W'(1000);
            4'hc: f_step_khz = FREQ_W'(1091);
            4'hd: f_step_khz = FREQ_W'(1200);
            4'he: f_step_khz = FREQ_W'(1333);
            default: f_step_khz = FREQ_W'(1500);
        endcase
    endfunction

    // Restoring divide of clock rate by a measured period, saturating
    function automatic logic [FREQ_W-1:0] f_period_khz(input logic [7:0] den);
        logic [15:0] rem;
        logic [14:0] q;
        logic [14:0] num;
        rem = '0;
        q = '0;
        num = 15'(swcs_pkg::CLK_KHZ);
        for (int i = 14; i >= 0; i--) begin
            rem = {rem[14:0], num[i]};
            if (rem >= {8'h00, den}) begin
                rem = rem - {8'h00, den};
                q[i] = 1'b1;
            end
        end
        if (q > 15'(swcs_pkg::FSW_SAT)) begin
            f_period_khz = swcs_pkg::FSW_SAT;
        end else begin
            f_period_khz = q[FREQ_W-1:0];
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, first stage read only by second
    logic [2:0] sync_pin_r;
    logic [1:0] en_pin_r;
    logic [1:0] strap_pin_r;
    always_ff @(posedge i_core_clk) begin
        sync_pin_r <= {sync_pin_r[1:0], i_freq_set_sync_pin};
        en_pin_r <= {en_pin_r[0], i_enable};
        strap_pin_r <= {strap_pin_r[0], i_addr_float};
    end
    logic sync_edge;
    assign sync_edge = sync_pin_r[1] & ~sync_pin_r[2];

    //////////////////////////////////////////////////////////////////////////
    // Init sequence: strap, then one ADC read in analog mode
    swcs_state_e state_r;
    logic [1:0] settle_r;
    logic analog_r;
    logic [FREQ_W-1:0] ana_khz_r;
    logic init_done_pulse;
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_r <= ST_STRAP;
            settle_r <= 2'h0;
            analog_r <= 1'b0;
            ana_khz_r <= FREQ_W'(swcs_pkg::FSW_DIG_RST);
        end else begin
            case (state_r)
                ST_STRAP: begin
                    settle_r <= settle_r + 2'h1;
                    if (settle_r == 2'(swcs_pkg::STRAP_SETTLE_CYC)) begin
                        analog_r <= strap_pin_r[1]; // R1
                        state_r <= strap_pin_r[1] ? ST_ADC : ST_RUN;
                    end
                end
                ST_ADC: if (i_adc_valid) begin
                    ana_khz_r <= f_step_khz(i_adc_data[9:6]); // R2 R4
                    state_r <= ST_RUN;
                end
                ST_RUN: state_r <= ST_RUN; // R3
                default: state_r <= ST_STRAP;
            endcase
        end
    end
    // Request stays up only while the single conversion is pending
    assign o_adc_req = (state_r == ST_ADC); // R2 R3
    assign init_done_pulse = (state_r != ST_RUN) && !i_srst &&
        (((state_r == ST_ADC) && i_adc_valid) ||
         ((state_r == ST_STRAP) && (settle_r == 2'(swcs_pkg::STRAP_SETTLE_CYC)) &&
          !strap_pin_r[1]));
    logic init_done;
    assign init_done = (state_r == ST_RUN);

    //////////////////////////////////////////////////////////////////////////
    // Sync edge timing and loss detection
    logic [7:0] gap_r;
    logic seen_r;
    logic sync_active_r;
    logic [FREQ_W-1:0] ext_khz_r;
    logic sync_lost;
    logic sync_acq;
    assign sync_lost = sync_active_r && !sync_edge &&
        (gap_r == 8'(swcs_pkg::SYNC_LOSS_CYC - 1)); // R15
    assign sync_acq = sync_edge && seen_r && !sync_active_r;
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            gap_r <= 8'h00;
            seen_r <= 1'b0;
            sync_active_r <= 1'b0;
            ext_khz_r <= '0;
        end else if (sync_edge) begin
            gap_r <= 8'h00;
            seen_r <= 1'b1;
            if (seen_r) begin
                sync_active_r <= 1'b1;
                ext_khz_r <= f_period_khz(gap_r + 8'h01);
            end
        end else if (gap_r == 8'(swcs_pkg::SYNC_LOSS_CYC - 1)) begin
            // Too long without an edge: clock counts as gone
            seen_r <= 1'b0;
            sync_active_r <= 1'b0; // R15
        end else begin
            gap_r <= gap_r + 8'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sync-at-init tracking and failure latch
    logic sync_at_init_r;
    logic fail_r;
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            sync_at_init_r <= 1'b0;
            fail_r <= 1'b0;
        end else begin
            if (init_done_pulse) begin
                sync_at_init_r <= analog_r && sync_active_r; // R7
            end
            // No resistor value to fall back on, so loss is fatal
            if (sync_lost && sync_at_init_r) begin
                fail_r <= 1'b1; // R8
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // APB registers
    logic [1:0] ctrl_r;
    logic [FREQ_W-1:0] fsw_prog_r;
    logic [swcs_pkg::IRQ_W-1:0] irq_stat_r;
    logic [swcs_pkg::IRQ_W-1:0] irq_mask_r;
    logic [swcs_pkg::IRQ_W-1:0] irq_set;
    logic wr_en;
    logic mapped;
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign mapped = (i_paddr == swcs_pkg::OFS_CTRL) || (i_paddr == swcs_pkg::OFS_FSW) ||
        (i_paddr == swcs_pkg::OFS_STATUS) || (i_paddr == swcs_pkg::OFS_FREQ) ||
        (i_paddr == swcs_pkg::OFS_IRQ_STAT) || (i_paddr == swcs_pkg::OFS_IRQ_MASK);
    assign o_pready = i_psel && i_penable;
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign irq_set = {init_done_pulse, sync_lost && sync_at_init_r, sync_lost, sync_acq};

    // Control and frequency; analog mode keeps its loaded setup
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ctrl_r <= swcs_pkg::CTRL_RST;
            fsw_prog_r <= FREQ_W'(swcs_pkg::FSW_DIG_RST); // R5
        end else if (wr_en && !analog_r) begin
            if (i_paddr == swcs_pkg::OFS_CTRL) begin
                ctrl_r <= i_pwdata[1:0]; // R14
            end
            if (i_paddr == swcs_pkg::OFS_FSW) begin
                // Out of range values clamp to the nearest limit
                if (i_pwdata[31:FREQ_W] != '0 ||
                    i_pwdata[FREQ_W-1:0] > swcs_pkg::FSW_DIG_MAX) begin
                    fsw_prog_r <= swcs_pkg::FSW_DIG_MAX; // R5
                end else if (i_pwdata[FREQ_W-1:0] < swcs_pkg::FSW_DIG_MIN) begin
                    fsw_prog_r <= swcs_pkg::FSW_DIG_MIN; // R5
                end else begin
                    fsw_prog_r <= i_pwdata[FREQ_W-1:0]; // R5
                end
            end
        end
    end

    // Interrupt status, write one to clear, set wins
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (wr_en && i_paddr == swcs_pkg::OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~i_pwdata[swcs_pkg::IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            if (wr_en && i_paddr == swcs_pkg::OFS_IRQ_MASK) begin
                irq_mask_r <= i_pwdata[swcs_pkg::IRQ_W-1:0];
            end
        end
    end
    assign o_irq = |(irq_stat_r & irq_mask_r);

    //////////////////////////////////////////////////////////////////////////
    // Frequency target and gradual slewing
    logic [FREQ_W-1:0] free_khz;
    logic [FREQ_W-1:0] target_khz;
    logic [4:0] slew_div_r;
    logic slew_tick;
    assign free_khz = analog_r ? ana_khz_r : fsw_prog_r; // R10
    assign target_khz = sync_active_r ? ext_khz_r : free_khz; // R9
    assign slew_tick = (slew_div_r == 5'(swcs_pkg::SLEW_STEP_CYC - 1));
    always_ff @(posedge i_core_clk) begin
        if (i_srst || slew_tick) begin
            slew_div_r <= 5'h00;
        end else begin
            slew_div_r <= slew_div_r + 5'h01;
        end
    end
    // One kHz per tick so the loop never sees a step
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_fsw_khz <= '0;
        end else if (init_done_pulse) begin
            // Step comes straight from the ADC word; its register loads on this edge
            o_fsw_khz <= (analog_r && !sync_active_r) ?
                f_step_khz(i_adc_data[9:6]) : target_khz; // R2
        end else if (init_done && slew_tick) begin
            if (o_fsw_khz < target_khz) begin
                o_fsw_khz <= o_fsw_khz + FREQ_W'(1); // R11 R12
            end else if (o_fsw_khz > target_khz) begin
                o_fsw_khz <= o_fsw_khz - FREQ_W'(1); // R11 R12
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Driver enables: immediate off, no soft stop
    logic run_ok;
    assign run_ok = en_pin_r[1] && init_done && !fail_r && // R13 R8
        !(!analog_r && ctrl_r[swcs_pkg::CTRL_OPCMD_EN_BIT] &&
          !ctrl_r[swcs_pkg::CTRL_OP_ON_BIT]); // R14
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_hs_drv_en <= 1'b0;
            o_ls_drv_en <= 1'b0;
        end else begin
            o_hs_drv_en <= run_ok; // R13
            o_ls_drv_en <= run_ok; // R13
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data captured in the setup phase
    swcs_pkg::swcs_stat_s stat;
    assign stat = '{conv_en: o_hs_drv_en, fail: fail_r, sync_at_init: sync_at_init_r,
        sync_active: sync_active_r, init_done: init_done, analog: analog_r};
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_prdata <= '0;
        end else if (i_psel && !i_penable) begin
            case (i_paddr)
                swcs_pkg::OFS_CTRL: o_prdata <= {30'h0, ctrl_r};
                swcs_pkg::OFS_FSW: o_prdata <= {{(32-FREQ_W){1'b0}}, fsw_prog_r};
                swcs_pkg::OFS_STATUS: o_prdata <= {26'h0, stat};
                swcs_pkg::OFS_FREQ: o_prdata <= {{(32-FREQ_W){1'b0}}, o_fsw_khz};
                swcs_pkg::OFS_IRQ_STAT: o_prdata <= {28'h0, irq_stat_r};
                swcs_pkg::OFS_IRQ_MASK: o_prdata <= {28'h0, irq_mask_r};
                default: o_prdata <= '0;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    a_slew_step: assert property (init_done && !init_done_pulse && $past(init_done) |->
        (o_fsw_khz - $past(o_fsw_khz) <= FREQ_W'(1)) ||
        ($past(o_fsw_khz) - o_fsw_khz <= FREQ_W'(1))) // R11
        else $error("switching frequency stepped by more than one");
    a_slew_back: assert property ($fell(sync_active_r) && !fail_r |=>
        ##[0:30] (o_fsw_khz != $past(o_fsw_khz)) || (o_fsw_khz == free_khz)) // R12
        else $error("no slewing toward free frequency after sync loss");
    a_drv_off: assert property (!en_pin_r[1] |=> !o_hs_drv_en && !o_ls_drv_en) // R13
        else $error("drivers still on after enable low");
    a_op_off: assert property (!analog_r && ctrl_r == 2'h1 |=> !o_hs_drv_en) // R14
        else $error("operation command shutdown ignored");
    a_sync_fail: assert property (sync_lost && sync_at_init_r |=> fail_r ##1 !o_hs_drv_en) // R8
        else $error("analog sync loss did not disable conversion");
    a_late_loss: assert property (sync_lost && !sync_at_init_r && !fail_r |=>
        !fail_r && target_khz == free_khz) // R9
        else $error("late sync loss did not fall back");
    a_loss_window: assert property (sync_active_r && sync_edge ##1 !sync_edge[*8] |->
        sync_active_r) // R15
        else $error("sync dropped before the loss window");
    a_adc_once: assert property (init_done |->
        !o_adc_req && (!$past(init_done) || $stable(ana_khz_r))) // R3
        else $error("analog setting changed after init");
    a_dig_free: assert property (init_done && !analog_r |-> free_khz == fsw_prog_r) // R10
        else $error("digital free frequency not from register");
    a_dig_range: assert property (fsw_prog_r >= swcs_pkg::FSW_DIG_MIN &&
        fsw_prog_r <= swcs_pkg::FSW_DIG_MAX) // R5
        else $error("programmed frequency out of range");
    a_mode_strap: assert property ($rose(init_done) && analog_r |-> $past(o_adc_req)) // R1
        else $error("analog mode entered without ADC read");

    c_sync_acq: cover property (sync_acq ##[1:1000] sync_lost);
    c_analog_fail: cover property (sync_at_init_r ##[1:500] fail_r);
    c_op_shutdown: cover property (o_hs_drv_en ##1 !o_hs_drv_en && en_pin_r[1]);
endmodule

// ### shared/swcs_pkg.sv
// Purpose: Constants and carrier types for the switching clock select block
// Assumes: 25 MHz core clock, APB register access with 32-bit data
// Notes: All frequencies are held in kHz
package swcs_pkg;
    // Core clock and timing
    localparam int CLK_KHZ = 25000;
    localparam int CLK_NS = 40;
    localparam int SYNC_LOSS_NS = 5000;
    localparam int SYNC_LOSS_CYC = (SYNC_LOSS_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLEW_STEP_NS = 1000;
    localparam int SLEW_STEP_CYC = SLEW_STEP_NS / CLK_NS;
    localparam int STRAP_SETTLE_CYC = 2;
    // Frequency limits and reset values, kHz
    localparam logic [11:0] FSW_DIG_RST = 12'h25f;
    localparam logic [11:0] FSW_DIG_MIN = 12'h0fa;
    localparam logic [11:0] FSW_DIG_MAX = 12'h5dc;
    localparam logic [11:0] FSW_SAT = 12'hfff;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FSW = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FREQ = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    // Control register fields and reset values
    localparam int CTRL_OPCMD_EN_BIT = 0;
    localparam int CTRL_OP_ON_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;
    // Interrupt bit positions
    localparam int IRQ_SYNC_ACQ = 0;
    localparam int IRQ_SYNC_LOST = 1;
    localparam int IRQ_FAIL = 2;
    localparam int IRQ_INIT_DONE = 3;
    localparam int IRQ_W = 4;
    // Status word, low bits of STATUS register
    typedef struct packed {
        logic conv_en;
        logic fail;
        logic sync_at_init;
        logic sync_active;
        logic init_done;
        logic analog;
    } swcs_stat_s;
endpackage

// ### sim/swcs_far_end.sv
// Purpose: Far side of the block, an external sync clock source and the setting ADC
// Assumes: Sync clock period 320 ns, phase fixed relative to the core clock, edges 7 ns before a rising edge
// Notes: ADC answers after a bench-chosen latency; data scrambles when not valid
`timescale 1ns/1ps
module swcs_far_end (
    input wire logic i_clk, // Core clock
    input wire logic i_run, // Sync clock applied when high
    input wire logic i_adc_req, // Conversion request from the block
    input wire logic [9:0] i_code, // Code seen by the converter
    input wire logic [3:0] i_lat, // Answer latency in cycles
    output logic o_sync, // Sync pin level
    output logic o_adc_valid, // Result strobe
    output logic [9:0] o_adc_data // Result
);
    logic [3:0] cnt_r = 4'h0;
    initial o_adc_valid = 1'b0;
    initial o_adc_data = 10'h000;
    //////////////////////////////////////////////////////////////////////////
    // Clock only while i_run is high; odd offset keeps edges off the core clock
    initial begin
        o_sync = 1'b0;
        #13;
        forever begin
            #160;
            o_sync = i_run ? ~o_sync : 1'b0;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // One result per request; data inverted when not valid so nothing stale shows
    always @(posedge i_clk) begin
        o_adc_valid <= 1'b0;
        o_adc_data <= ~o_adc_data;
        if (!i_adc_req || o_adc_valid) begin
            cnt_r <= i_lat;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end else begin
            o_adc_valid <= 1'b1;
            o_adc_data <= i_code;
        end
    end
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench for the switching clock select block
// Assumes: APB master with zero or more wait states, fixed xorshift seed
// Notes: Slew is measured over whole ticks, so edge phase does not matter
`timescale 1ns/1ps
module testbench;
    localparam int TAB[16] = '{306, 356, 400, 444, 500, 550, 600, 706,
                               750, 800, 923, 1000, 1091, 1200, 1333, 1500};
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'he938cea6, v;
    logic pready, pslverr, last_err, flt = 1'b0, en = 1'b1, run = 1'b0;
    logic sync, adc_req, adc_vld, hs, ls, irq;
    logic [9:0] adc_data, code = 10'h000;
    logic [3:0] lat = 4'h2;
    logic [11:0] fsw, f0;
    int failures = 0, n_compared = 0;
    always #20 clk = ~clk;
    swcs_top u_dut (.i_core_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_addr_float(flt),
        .i_freq_set_sync_pin(sync), .i_enable(en), .o_adc_req(adc_req),
        .i_adc_valid(adc_vld), .i_adc_data(adc_data), .o_fsw_khz(fsw),
        .o_hs_drv_en(hs), .o_ls_drv_en(ls), .o_irq(irq));
    swcs_far_end u_far (.i_clk(clk), .i_run(run), .i_adc_req(adc_req), .i_code(code),
        .i_lat(lat), .o_sync(sync), .o_adc_valid(adc_vld), .o_adc_data(adc_data));
    //////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] clamp(input logic [31:0] x);
        return (x > 32'd1500) ? 32'd1500 : ((x < 32'd250) ? 32'd250 : x);
    endfunction
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Request held until pready is seen high; data taken at that edge only
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin failures++; summarize(); end
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic wait_stat(input int b, input logic val);
        int n;
        n = 0;
        do begin apb(1'b0, swcs_pkg::OFS_STATUS, 32'h0); n++; end
            while (q[b] !== val && n < 200);
        chk("status bit wait", {31'h0, val}, {31'h0, q[b]});
        if (q[b] !== val) summarize();
    endtask
    task automatic do_reset(input logic f, input logic r);
        @(posedge clk);
        srst <= 1'b1; flt <= f; run <= r; en <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        wait_stat(1, 1'b1);
    endtask
    task automatic slew(input string nm, input int sgn);
        f0 = fsw;
        repeat (250) @(posedge clk);
        #1;
        v = sgn * (int'(fsw) - int'(f0));
        chk(nm, 32'h1, {31'h0, v >= 9 && v <= 11});
    endtask
    //////////////////////////////////////////////////////////////////////////
    // Watchdog, counts as a mismatch
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        summarize();
    end
    //////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset(1'b0, 1'b0);
        apb(1'b0, swcs_pkg::OFS_FSW, 32'h0); chk("fsw reset", 32'd607, q);
        apb(1'b0, swcs_pkg::OFS_CTRL, 32'h0); chk("ctrl reset", 32'h2, q);
        chk("fsw out", 32'd607, {20'h0, fsw});
        apb(1'b0, swcs_pkg::OFS_FREQ, 32'h0);
        chk("freq reg", 32'd607, q);
        chk("drivers on", 32'h3, {30'h0, hs, ls});
        for (int i = 0; i < 12; i++) begin
            case (i)
                0: v = 32'd249; 1: v = 32'd250; 2: v = 32'd251; 3: v = 32'd1454;
                4: v = 32'd1501; 5: v = 32'h10000;
                default: v = xs() & (i[0] ? 32'h7ff : 32'hffffffff);
            endcase
            apb(1'b1, swcs_pkg::OFS_FSW, v);
            apb(1'b0, swcs_pkg::OFS_FSW, 32'h0); chk("fsw clamp", clamp(v), q);
        end
        apb(1'b1, swcs_pkg::OFS_FSW, 32'd607);
        apb(1'b0, 8'h40, 32'h0); chk("unmapped err", 32'h1, {31'h0, last_err});
        chk("unmapped read", 32'h0, q);
        // Interrupt: raise through mask, then clear by writing one
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, swcs_pkg::OFS_IRQ_MASK, 32'h8); @(posedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, swcs_pkg::OFS_IRQ_STAT, 32'h8); @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Operation command shutdown, then enable pin shutdown
        apb(1'b1, swcs_pkg::OFS_CTRL, 32'h1); repeat (2) @(posedge clk);
        chk("op shutdown", 32'h0, {30'h0, hs, ls});
        apb(1'b1, swcs_pkg::OFS_CTRL, 32'h3); repeat (2) @(posedge clk);
        chk("op on", 32'h3, {30'h0, hs, ls});
        en <= 1'b0; repeat (5) @(posedge clk);
        chk("enable off", 32'h0, {30'h0, hs, ls});
        en <= 1'b1; repeat (5) @(posedge clk);
        $display("test digital registers done");
        // Sync applied after init, then removed: slews, no shutdown
        run <= 1'b1; wait_stat(2, 1'b1);
        slew("slew up", 1);
        run <= 1'b0; wait_stat(2, 1'b0);
        apb(1'b0, swcs_pkg::OFS_IRQ_STAT, 32'h0); chk("irq sync bits", 32'h3, q & 32'h7);
        chk("drivers after loss", 32'h3, {30'h0, hs, ls});
        slew("slew down", -1);
        $display("test digital sync done");
        // Analog: every resistor step, then pin change after init ignored
        for (int k = 0; k < 16; k++) begin
            v = xs();
            code <= {k[3:0], v[5:0]}; lat <= v[9:6];
            do_reset(1'b1, 1'b0);
            chk("analog fsw", TAB[k], {20'h0, fsw});
            // Setup writes are locked out in analog mode
            apb(1'b1, swcs_pkg::OFS_CTRL, 32'h1);
            apb(1'b1, swcs_pkg::OFS_FSW, v);
            apb(1'b0, swcs_pkg::OFS_FSW, 32'h0);
            chk("analog fsw locked", 32'd607, q);
            code <= ~code; repeat (30) @(posedge clk); #1;
            chk("analog held", TAB[k], {20'h0, fsw});
            chk("analog drivers", 32'h3, {30'h0, hs, ls});
            chk("adc idle", 32'h0, {31'h0, adc_req});
        end
        $display("test analog table done");
        // Analog with sync present at init: loss is a failure
        // Slowest ADC answer so two sync edges land before init ends
        lat <= 4'hf;
        do_reset(1'b1, 1'b1);
        wait_stat(2, 1'b1);
        apb(1'b0, swcs_pkg::OFS_STATUS, 32'h0); chk("sync at init", 32'h1, {31'h0, q[3]});
        run <= 1'b0; wait_stat(4, 1'b1);
        repeat (2) @(posedge clk);
        chk("fail drivers", 32'h0, {30'h0, hs, ls});
        $display("test analog sync loss done");
        summarize();
    end
endmodule
